/* File: rtl/wes_pkg.sv */
// constants and types shared by the wake event register block
package wes_pkg;
  // register map
  localparam int          WES_ADDR_W    = 12;
  localparam logic [11:0] WES_CTRL_OFS  = 12'h140;
  localparam logic [11:0] WES_SRC_OFS   = 12'h144;
  // wake control/status field positions
  localparam int          CB_BROADCAST_WAKE_ENABLE   = 0;
  localparam int          CB_PKT_EN     = 1;
  localparam int          CB_PAT_EN     = 2;
  localparam int          CB_DEST_EN    = 3;
  localparam int          CB_BCAST_SEEN = 4;
  localparam int          CB_PKT_SEEN   = 5;
  localparam int          CB_CLR_STS    = 16;
  localparam int          CB_CLR_EN     = 17;
  localparam int          CB_LPI_RX_EN  = 18;
  localparam int          CB_LPI_TX_EN  = 19;
  localparam int          CB_ESAVE_EN   = 20;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] CTRL_STORE_M  = 32'h001f_000f;
  localparam logic [31:0] CTRL_EN_M     = 32'h000c_000f;
  localparam logic [31:0] CTRL_SEEN_M   = 32'h0000_0030;
  // wake source field positions
  localparam int          SB_PIN_LO     = 20;
  localparam int          SB_V6         = 16;
  localparam int          SB_V4         = 15;
  localparam int          SB_LPI_TX     = 14;
  localparam int          SB_LPI_RX     = 13;
  localparam int          SB_FE         = 12;
  localparam int          SB_DEST       = 11;
  localparam int          SB_PKT        = 10;
  localparam int          SB_BCAST      = 9;
  localparam int          SB_PAT        = 8;
  localparam int          PIN_W         = 12;
  localparam logic [31:0] SRC_RST       = 32'h0000_0000;
  localparam logic [31:0] SRC_FLAG_M    = 32'hfff1_ff00;
  localparam logic [31:0] SRC_RW_M      = 32'hfff1_ff1f;
  // pattern filter bank seen by the index field
  localparam int          PAT_FILTERS   = 32;
  localparam int          PAT_BYTES     = 128;
  localparam int          IDX_W         = $clog2(PAT_FILTERS);
  // power sequencing as seen by the source recorder
  typedef enum logic [1:0] {
    WES_ACTIVE,
    WES_ENTERING,
    WES_SUSPENDED,
    WES_WAKING
  } wes_state_t;
endpackage

/* File: rtl/wes_wake_regs.sv */
// wake enables, received-event flags and wake source recorder
`timescale 1ns/1ns
module wes_wake_regs (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  // register port
  input  wire logic [wes_pkg::WES_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [31:0]                   reg_rdata_o,
  // power sequencing
  input  wire logic                          suspend_begin_i,
  input  wire logic                          suspend_done_i,
  input  wire logic                          resume_done_i,
  // receive and pin events, one cycle pulses
  input  wire logic                          broadcast_rx_i,
  input  wire logic                          dest_match_rx_i,
  input  wire logic                          wake_packet_rx_i,
  input  wire logic                          pattern_rx_i,
  input  wire logic [wes_pkg::IDX_W-1:0]     pattern_index_i,
  input  wire logic                          filter_engine_rx_i,
  input  wire logic                          v4_syn_rx_i,
  input  wire logic                          v6_syn_rx_i,
  input  wire logic                          lpi_tx_exit_i,
  input  wire logic                          lpi_rx_exit_i,
  input  wire logic [wes_pkg::PIN_W-1:0]     pin_wake_i,
  // status out
  output logic                               wake_signal_o,
  output logic                               suspend_state_o,
  output logic      [3:0]                    wake_enables_o
);
  import wes_pkg::*;

  logic [31:0]       ctrl_r;
  logic [31:0]       ctrl_nxt;
  logic [31:0]       src_r;
  logic [31:0]       src_nxt;
  logic [31:0]       set_v;
  logic [31:0]       clr_v;
  logic [31:0]       flags;
  logic [31:0]       seen_ev;
  logic [31:0]       seen_keep;
  logic [IDX_W-1:0]  idx;
  logic              wr_ctrl;
  logic              wr_src;
  logic              any_q;
  logic              suspended;
  wes_state_t        state_r;
  wes_state_t        state_nxt;

  assign wr_ctrl   = reg_wr_i && (reg_addr_i == WES_CTRL_OFS);
  assign wr_src    = reg_wr_i && (reg_addr_i == WES_SRC_OFS);
  assign suspended = (state_r == WES_SUSPENDED);

  // seen flags are not gated by power state; they follow the MAC directly
  always_comb begin
    seen_ev                = '0;
    seen_ev[CB_BCAST_SEEN] = broadcast_rx_i;
    seen_ev[CB_PKT_SEEN]   = wake_packet_rx_i;
  end

  always_comb begin
    ctrl_nxt = ctrl_r & CTRL_STORE_M;
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata_i & CTRL_STORE_M;
    end else if (resume_done_i && ctrl_r[CB_CLR_EN]) begin
      ctrl_nxt = ctrl_nxt & ~CTRL_EN_M;
    end
    seen_keep = ctrl_r & CTRL_SEEN_M;
    if (wr_ctrl) begin
      seen_keep = seen_keep & ~reg_wdata_i;
    end
    if (resume_done_i && ctrl_r[CB_CLR_STS]) begin
      seen_keep = '0;
    end
    // a new event outweighs any clear in the same cycle
    ctrl_nxt = ctrl_nxt | seen_keep | seen_ev;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // only a fully suspended device records; entry and waking are blind
  always_comb begin
    set_v = '0;
    if (suspended) begin
      set_v[SB_PIN_LO +: PIN_W] = pin_wake_i;
      set_v[SB_V6]     = v6_syn_rx_i;
      set_v[SB_V4]     = v4_syn_rx_i;
      set_v[SB_LPI_TX] = lpi_tx_exit_i && ctrl_r[CB_LPI_TX_EN]
                         && ctrl_r[CB_ESAVE_EN];
      set_v[SB_LPI_RX] = lpi_rx_exit_i && ctrl_r[CB_LPI_RX_EN]
                         && ctrl_r[CB_ESAVE_EN];
      set_v[SB_FE]     = filter_engine_rx_i;
      set_v[SB_DEST]   = dest_match_rx_i
                         && ctrl_r[CB_DEST_EN];
      set_v[SB_PKT]    = wake_packet_rx_i
                         && ctrl_r[CB_PKT_EN];
      set_v[SB_BCAST]  = broadcast_rx_i
                         && ctrl_r[CB_BROADCAST_WAKE_ENABLE];
      set_v[SB_PAT]    = pattern_rx_i
                         && ctrl_r[CB_PAT_EN];
    end
  end

  assign any_q = |set_v;
  assign clr_v = wr_src ? reg_wdata_i : 32'h0000_0000;

  always_comb begin
    // every qualifying condition is or-ed in, none excludes another
    flags = ((src_r & ~clr_v) | set_v) & SRC_FLAG_M;
    if (!ctrl_r[CB_ESAVE_EN]) begin
      flags[SB_LPI_TX] = 1'b0;
      flags[SB_LPI_RX] = 1'b0;
    end
    idx = src_r[IDX_W-1:0];
    if (set_v[SB_PAT]) begin
      idx = pattern_index_i;
    end else if (clr_v[IDX_W-1:0] != '0) begin
      idx = '0;
    end
    src_nxt = (flags | {{(32-IDX_W){1'b0}}, idx}) & SRC_RW_M;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_r <= SRC_RST;
    end else begin
      src_r <= src_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WES_ACTIVE: begin
        if (suspend_begin_i) begin
          state_nxt = WES_ENTERING;
        end
      end
      WES_ENTERING: begin
        if (suspend_done_i) begin
          state_nxt = WES_SUSPENDED;
        end
      end
      WES_SUSPENDED: begin
        if (any_q) begin
          state_nxt = WES_WAKING;
        end else if (resume_done_i) begin
          state_nxt = WES_ACTIVE;
        end
      end
      WES_WAKING: begin
        if (resume_done_i) begin
          state_nxt = WES_ACTIVE;
        end
      end
      default: begin
        state_nxt = WES_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= WES_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_signal_o   <= 1'b0;
      suspend_state_o <= 1'b0;
      wake_enables_o  <= 4'h0;
    end else begin
      wake_signal_o   <= suspended && any_q;
      suspend_state_o <= (state_nxt == WES_SUSPENDED);
      wake_enables_o  <= ctrl_nxt[3:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && (reg_addr_i == WES_CTRL_OFS)) begin
      reg_rdata_o <= ctrl_r;
    end else if (reg_rd_i && (reg_addr_i == WES_SRC_OFS)) begin
      reg_rdata_o <= src_r;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  sequence wake_hit_s;
    suspended && any_q;
  endsequence

  sequence waking_hold_s;
    (state_r == WES_WAKING) && !resume_done_i;
  endsequence

  pkt_seen_set_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wake_packet_rx_i |=> ctrl_r[CB_PKT_SEEN])
    else $error("wake packet seen flag not set");

  bcast_seen_set_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    broadcast_rx_i |=> ctrl_r[CB_BCAST_SEEN])
    else $error("broadcast seen flag not set");

  resume_sts_clr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    resume_done_i && ctrl_r[CB_CLR_STS] && !broadcast_rx_i
      && !wake_packet_rx_i |=> (ctrl_r & CTRL_SEEN_M) == 32'h0000_0000)
    else $error("resume left seen flags set");

  resume_en_clr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    resume_done_i && ctrl_r[CB_CLR_EN] && !wr_ctrl
      |=> (ctrl_r & CTRL_EN_M) == 32'h0000_0000 && wake_enables_o == 4'h0)
    else $error("resume left enables set");

  dest_wake_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended && dest_match_rx_i && ctrl_r[CB_DEST_EN]
      |=> src_r[SB_DEST] && wake_signal_o && state_r == WES_WAKING)
    else $error("destination match wake not recorded");

  no_record_idle_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !suspended |=> (src_r & ~$past(src_r)) == 32'h0000_0000)
    else $error("source recorded outside suspend");

  waking_blind_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wake_hit_s ##1 waking_hold_s |=> !wake_signal_o
      && (src_r & ~$past(src_r)) == 32'h0000_0000)
    else $error("event recorded while waking");

  src_sticky_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_src && ctrl_r[CB_ESAVE_EN]
      |=> (src_r & $past(src_r)) == $past(src_r))
    else $error("source field lost without a clear");

  lpi_held_low_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ctrl_r[CB_ESAVE_EN] |=> !src_r[SB_LPI_TX] && !src_r[SB_LPI_RX])
    else $error("low power source set while saving off");

  set_beats_clr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_src && set_v[SB_PAT] |=> src_r[SB_PAT]
      && src_r[IDX_W-1:0] == $past(pattern_index_i))
    else $error("clear beat a new pattern wake");

  src_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == WES_SRC_OFS |=> reg_rdata_o == $past(src_r))
    else $error("source read data wrong");

  reserved_zero_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (src_r & ~SRC_RW_M) == 32'h0000_0000)
    else $error("reserved source bits set");

  enable_wr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl |=> ctrl_r[3:0] == $past(reg_wdata_i[3:0])
      && wake_enables_o == ctrl_r[3:0])
    else $error("wake enables not written");

  seen_wr_clr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl && reg_wdata_i[CB_PKT_SEEN] && !wake_packet_rx_i
      |=> !ctrl_r[CB_PKT_SEEN])
    else $error("wake packet seen flag not cleared");

  pat_index_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended && pattern_rx_i && ctrl_r[CB_PAT_EN] |=> src_r[SB_PAT]
      && src_r[IDX_W-1:0] == $past(pattern_index_i))
    else $error("pattern index not recorded");

  pin_record_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended |=> (src_r[SB_PIN_LO +: PIN_W] & $past(pin_wake_i))
      == $past(pin_wake_i))
    else $error("pin wake source not recorded");

  syn_src_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended |=> (src_r[SB_V6] || !$past(v6_syn_rx_i))
      && (src_r[SB_V4] || !$past(v4_syn_rx_i)))
    else $error("syn wake source not recorded");

  lpi_tx_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    lpi_tx_exit_i && !src_r[SB_LPI_TX]
      && !(ctrl_r[CB_LPI_TX_EN] && ctrl_r[CB_ESAVE_EN])
      |=> !src_r[SB_LPI_TX])
    else $error("low power transmit wake without enable");

  lpi_rx_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    lpi_rx_exit_i && !src_r[SB_LPI_RX]
      && !(ctrl_r[CB_LPI_RX_EN] && ctrl_r[CB_ESAVE_EN])
      |=> !src_r[SB_LPI_RX])
    else $error("low power receive wake without enable");

  bcast_src_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended && broadcast_rx_i && ctrl_r[CB_BROADCAST_WAKE_ENABLE] |=> src_r[SB_BCAST])
    else $error("broadcast wake source not recorded");

  pkt_src_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    suspended && wake_packet_rx_i && ctrl_r[CB_PKT_EN] |=> src_r[SB_PKT])
    else $error("wake packet source not recorded");
endmodule

/* File: tb/wes_far_model.sv */
// far-side model: frame detectors and suspend/resume sequencing
`timescale 1ns/1ns
module wes_far_model (
  // clock
  input  wire logic                      core_clk_i,
  // pulses, msb first: resume, suspend done, suspend begin, lpi rx,
  // lpi tx, v6, v4, filter engine, pattern, wake packet, dest, bcast
  output logic      [11:0]               ev_o,
  output logic      [wes_pkg::IDX_W-1:0] idx_o,
  output logic      [wes_pkg::PIN_W-1:0] pins_o
);
  import wes_pkg::*;
  initial begin
    ev_o   = '0;
    idx_o  = '0;
    pins_o = '0;
  end
  // one-cycle pulses; the index means nothing without the pattern pulse,
  // so it is inverted once released rather than left looking valid
  task automatic send(input logic [11:0]      ev,
                      input logic [IDX_W-1:0] idx,
                      input logic [PIN_W-1:0] pins);
    @(posedge core_clk_i);
    ev_o   <= ev;
    idx_o  <= idx;
    pins_o <= pins;
    @(posedge core_clk_i);
    ev_o   <= '0;
    idx_o  <= ~idx;
    pins_o <= '0;
  endtask
endmodule

/* File: tb/wake_event_enable_and_source_bench.sv */
// self-checking bench for the wake event register block
`timescale 1ns/1ns
module wake_event_enable_and_source_bench;
  import wes_pkg::*;
  localparam logic [11:0] E_BC = 12'h001, E_DM = 12'h002, E_PK = 12'h004,
                          E_PT = 12'h008, E_FE = 12'h010, E_V4 = 12'h020,
                          E_V6 = 12'h040, E_LT = 12'h080, E_LR = 12'h100,
                          E_SB = 12'h200, E_SD = 12'h400, E_RD = 12'h800;
  localparam logic [11:0] CT = WES_CTRL_OFS;
  localparam logic [11:0] SR = WES_SRC_OFS;
  logic             core_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
  logic [11:0]      reg_addr_i, ev;
  logic [31:0]      reg_wdata_i, reg_rdata_o;
  logic             suspend_begin_i, suspend_done_i, resume_done_i;
  logic             broadcast_rx_i, dest_match_rx_i, wake_packet_rx_i;
  logic             pattern_rx_i, filter_engine_rx_i, v4_syn_rx_i;
  logic             v6_syn_rx_i, lpi_tx_exit_i, lpi_rx_exit_i;
  logic             wake_signal_o, suspend_state_o;
  logic [IDX_W-1:0] pattern_index_i;
  logic [PIN_W-1:0] pin_wake_i;
  logic [3:0]       wake_enables_o;
  int               n_fail = 0;
  int               n_tests = 0;
  int               cyc = 0;
  wes_wake_regs i_dut (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .suspend_begin_i, .suspend_done_i,
    .resume_done_i, .broadcast_rx_i, .dest_match_rx_i, .wake_packet_rx_i,
    .pattern_rx_i, .pattern_index_i, .filter_engine_rx_i, .v4_syn_rx_i,
    .v6_syn_rx_i, .lpi_tx_exit_i, .lpi_rx_exit_i, .pin_wake_i,
    .wake_signal_o, .suspend_state_o, .wake_enables_o);
  wes_far_model i_far (.core_clk_i, .ev_o(ev), .idx_o(pattern_index_i),
    .pins_o(pin_wake_i));
  assign {resume_done_i, suspend_done_i, suspend_begin_i, lpi_rx_exit_i,
          lpi_tx_exit_i, v6_syn_rx_i, v4_syn_rx_i, filter_engine_rx_i,
          pattern_rx_i, wake_packet_rx_i, dest_match_rx_i,
          broadcast_rx_i} = ev;
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // the whole run needs about a hundred cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic t_reset();
    chk({wake_signal_o, suspend_state_o, wake_enables_o}, 0);
    rdc(CT, 32'h0);
    rdc(SR, 32'h0);
    rdc(12'h148, 32'h0);
  endtask
  task automatic t_seen();
    wr(CT, 32'h0000_000f);
    #1 chk(wake_enables_o, 4'hf);
    i_far.send(E_BC | E_PK, 5'h0, 12'h0);
    rdc(CT, 32'h0000_003f);
    rdc(SR, 32'h0);
    wr(CT, 32'h0000_002f);
    rdc(CT, 32'h0000_001f);
    wr(CT, 32'h0000_001f);
    rdc(CT, 32'h0000_000f);
  endtask
  task automatic t_entry();
    i_far.send(E_SB, 5'h0, 12'h0);
    i_far.send(E_V4 | E_DM, 5'h0, 12'h0);
    i_far.send(E_SD, 5'h0, 12'h0);
    #1 chk(suspend_state_o, 1'b1);
    rdc(SR, 32'h0);
  endtask
  task automatic t_multi();
    i_far.send(E_BC | E_DM | E_PK | E_PT | E_FE | E_V4 | E_V6, 5'h13,
               12'h801);
    #1 chk({wake_signal_o, suspend_state_o}, 2'b10);
    @(posedge core_clk_i);
    #1 chk(wake_signal_o, 1'b0);
    rdc(SR, 32'h8011_9f13);
    repeat (3) @(posedge core_clk_i);
    rdc(SR, 32'h8011_9f13);
    wr(SR, 32'hffff_ffff);
    rdc(SR, 32'h0);
    i_far.send(E_V4 | E_PT, 5'h07, 12'h002);
    rdc(SR, 32'h0);
    wr(CT, 32'h0003_000f);
    rdc(CT, 32'h0003_003f);
    i_far.send(E_RD, 5'h0, 12'h0);
    rdc(CT, 32'h0003_0000);
    chk(wake_enables_o, 4'h0);
  endtask
  task automatic t_gate();
    wr(CT, 32'h000c_0000);
    i_far.send(E_SB, 5'h0, 12'h0);
    i_far.send(E_SD, 5'h0, 12'h0);
    i_far.send(E_BC | E_DM | E_PK | E_PT | E_LT | E_LR, 5'h01, 12'h0);
    #1 chk(wake_signal_o, 1'b0);
    rdc(SR, 32'h0);
    wr(CT, 32'h001c_0030);
    i_far.send(E_LT | E_LR, 5'h0, 12'h0);
    #1 chk(wake_signal_o, 1'b1);
    rdc(SR, 32'h0000_6000);
    wr(CT, 32'h000c_0000);
    rdc(SR, 32'h0);
    i_far.send(E_RD, 5'h0, 12'h0);
  endtask
  // a software clear landing with a new pattern wake must lose
  task automatic t_race();
    wr(CT, 32'h0000_0004);
    i_far.send(E_SB, 5'h0, 12'h0);
    i_far.send(E_SD, 5'h0, 12'h0);
    fork
      wr(SR, 32'hffff_ffff);
      i_far.send(E_PT, 5'h0a, 12'h0);
    join
    #1 chk(wake_signal_o, 1'b1);
    rdc(SR, 32'h0000_010a);
    i_far.send(E_RD, 5'h0, 12'h0);
  endtask
  initial begin
    rst_n_i     = 1'b0;
    reg_addr_i  = '0;
    reg_wdata_i = '0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_seen();
    t_entry();
    t_multi();
    t_gate();
    t_race();
    give_verdict();
  end
endmodule
